// ---- core/asr_regs.sv ----
// angle, status and error register group of the angle sensor core
module asr_regs
  import asr_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // angle path
  input wire logic [11:0] angle_code,
  input wire logic uvd_level,
  input wire logic uva_level,
  // nonvolatile masks
  input wire logic [11:0] error_mask,
  input wire logic [11:0] warning_mask,
  // error sources
  input wire logic [11:0] warning_events,
  input wire logic selftest_failed,
  input wire logic averaging_fault,
  input wire logic quadrature_integrity_fault,
  input wire logic loop_lock_lost,
  input wire logic zero_crossing_timeout,
  input wire logic nvm_multibit_error,
  input wire logic nvm_loading,
  input wire logic oscillator_watchdog_fault,
  input wire logic magnet_low_fault,
  // status sources
  input wire logic rotation_direction,
  input wire logic too_fast_for_sleep,
  input wire logic logic_selftest_running,
  input wire logic frontend_selftest_running,
  input wire logic boot_in_progress,
  input wire logic loop_locked,
  input wire logic startup_complete,
  input wire logic boot_complete,
  input wire logic nvm_loaded,
  input wire logic [1:0] nvm_die_identifier,
  input wire logic action_complete,
  // action requests and error summary
  output logic start_frontend_test,
  output logic start_logic_test,
  output logic turns_counter_reset,
  output logic hard_reset_request,
  output logic error_summary
);

  typedef struct packed {
    logic [3:0] action_select;
    logic [11:0] err;
    logic [11:0] err_seen;
    logic [11:0] warn;
    logic [11:0] warn_seen;
    logic boot_done;
    logic action_done;
    logic [1:0] die_identifier;
    logic [15:0] rdata;
    logic fe_start;
    logic logic_start;
    logic turns_reset;
    logic hard_reset;
  } asr_state_s;

  localparam asr_state_s ST_RESET = '{
    action_select: SEL_RESET,
    err: ERROR_RESET, // [RULE_24]
    err_seen: 12'h000,
    warn: WARN_RESET,
    warn_seen: 12'h000,
    boot_done: 1'b0,
    action_done: 1'b0,
    die_identifier: 2'h0,
    rdata: 16'h0000,
    fe_start: 1'b0,
    logic_start: 1'b0,
    turns_reset: 1'b0,
    hard_reset: 1'b0
  };

  asr_state_s s;
  asr_state_s next_s;

  // true when the select code arms the given trigger byte
  function automatic logic arms(input logic [3:0] sel, input logic [7:0] trig);
    logic hit;
    hit = 1'b0;
    unique case (trig)
      TRIG_TEST: hit = (sel == ACT_FE_TEST) || (sel == ACT_LOGIC_TEST) ||
                       (sel == ACT_BOTH_TEST); // [RULE_25]
      TRIG_TURNS: hit = (sel == ACT_TURNS);
      TRIG_HARD: hit = (sel == ACT_HARD);
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  // odd parity over the angle word
  function automatic logic odd_fill(input logic [14:0] bits);
    return ~(^bits);
  endfunction

  logic ctrl_wr;
  logic err_rd;
  logic warn_rd;
  logic status_clr;
  logic warn_clr;
  logic err_clr;
  logic trig_hit;
  logic [7:0] trig_byte;
  logic [3:0] sel_now;
  logic uv_summary;
  logic warn_pending;
  logic [11:0] err_events;
  logic [14:0] angle_body;
  logic [15:0] angle_word;
  logic [15:0] status_word;
  logic [15:0] read_mux;

  // decode of the register port
  assign ctrl_wr = reg_wr && (reg_addr == CTRL_OFS);
  assign err_rd = reg_rd && (reg_addr == ERROR_OFS);
  assign warn_rd = reg_rd && (reg_addr == WARN_OFS);
  assign status_clr = ctrl_wr && reg_wdata[STATUS_CLR_BIT];
  assign warn_clr = ctrl_wr && reg_wdata[WARN_CLR_BIT];
  assign err_clr = ctrl_wr && reg_wdata[ERROR_CLR_BIT];
  assign trig_byte = reg_wdata[7:0];
  assign sel_now = reg_wdata[SEL_LSB +: 4];
  // the select written with the trigger byte takes part, so one write may do both
  assign trig_hit = ctrl_wr && arms(sel_now, trig_byte); // [RULE_04]

  // live undervoltage, each source masked separately
  assign uv_summary = (uvd_level && !error_mask[ERR_UVD]) ||
                      (uva_level && !error_mask[ERR_UVA]); // [RULE_07]

  // unmasked warnings feed the warning-summary error bit
  assign warn_pending = |(s.warn & ~warning_mask); // [RULE_19]

  // error sources in register bit order, bit 0 only set by reset
  always_comb begin
    err_events = 12'h000;
    // the mask keeps the summary bit itself from latching; error_summary still takes warn_pending unmasked
    err_events[ERR_WAR] = warn_pending && !error_mask[ERR_WAR]; // [RULE_19]
    err_events[10] = selftest_failed; // [RULE_20]
    err_events[9] = averaging_fault; // [RULE_20]
    err_events[8] = quadrature_integrity_fault; // [RULE_21]
    err_events[7] = loop_lock_lost; // [RULE_21]
    err_events[6] = zero_crossing_timeout; // [RULE_21]
    // multi-bit errors only count during the load window
    err_events[5] = nvm_multibit_error && nvm_loading; // [RULE_23]
    err_events[4] = oscillator_watchdog_fault; // [RULE_21]
    // level inputs re-set every cycle, so a clear only sticks once gone
    err_events[ERR_UVD] = uvd_level; // [RULE_22]
    err_events[ERR_UVA] = uva_level; // [RULE_21]
    err_events[1] = magnet_low_fault;
  end

  // summary of every unmasked latched flag
  assign error_summary = |(s.err & ~error_mask) | warn_pending; // [RULE_06]

  // angle word: zero, summary, undervoltage, parity, angle
  assign angle_body = {1'b0, error_summary, uv_summary, angle_code}; // [RULE_05]
  assign angle_word = {angle_body[14:12], odd_fill(angle_body), angle_body[11:0]}; // [RULE_08]

  // status word with fixed identifier
  assign status_word = {STATUS_ID, // [RULE_09]
                        2'b00,
                        s.die_identifier, // [RULE_10]
                        rotation_direction, // [RULE_11]
                        too_fast_for_sleep, // [RULE_12]
                        s.action_done,
                        s.boot_done,
                        logic_selftest_running, // [RULE_15]
                        frontend_selftest_running, // [RULE_15]
                        boot_in_progress, // [RULE_16]
                        loop_locked && startup_complete}; // [RULE_17]

  // read multiplexer; strobes and trigger read back as zero
  always_comb begin
    unique case (reg_addr)
      CTRL_OFS: read_mux = {s.action_select, 12'h000}; // [RULE_02] [RULE_03]
      ANGLE_OFS: read_mux = angle_word;
      STATUS_OFS: read_mux = status_word;
      ERROR_OFS: read_mux = {ERROR_ID, s.err}; // [RULE_09]
      WARN_OFS: read_mux = {WARN_ID, s.warn};
      default: read_mux = 16'h0000;
    endcase
  end

  // next state
  always_comb begin
    next_s = s;
    next_s.fe_start = 1'b0;
    next_s.logic_start = 1'b0;
    next_s.turns_reset = 1'b0;
    next_s.hard_reset = 1'b0;
    if (reg_rd) begin
      next_s.rdata = read_mux;
    end
    // select field: written by host, returns to no action on completion
    if (ctrl_wr) begin
      next_s.action_select = sel_now;
    end else if (action_complete) begin
      next_s.action_select = ACT_NONE;
    end
    // action starts
    if (trig_hit) begin
      next_s.fe_start = (sel_now == ACT_FE_TEST) || (sel_now == ACT_BOTH_TEST); // [RULE_25]
      next_s.logic_start = (sel_now == ACT_LOGIC_TEST) || (sel_now == ACT_BOTH_TEST);
      next_s.turns_reset = (sel_now == ACT_TURNS); // [RULE_04]
      next_s.hard_reset = (sel_now == ACT_HARD); // [RULE_04]
    end
    // action done: trigger or status clear drop it, completion wins
    if (trig_hit || status_clr) begin
      next_s.action_done = 1'b0; // [RULE_13] [RULE_01]
    end
    if (action_complete) begin
      next_s.action_done = 1'b1; // [RULE_13]
    end
    // boot done: held until status clear, a fresh completion wins
    if (status_clr) begin
      next_s.boot_done = 1'b0; // [RULE_01]
    end
    if (boot_complete) begin
      next_s.boot_done = 1'b1; // [RULE_14]
    end
    if (nvm_loaded) begin
      next_s.die_identifier = nvm_die_identifier; // [RULE_10]
    end
    // error flags: only bits already returned are cleared, events win
    if (err_clr) begin
      next_s.err = s.err & ~s.err_seen; // [RULE_03] [RULE_26]
      next_s.err_seen = 12'h000;
    end
    next_s.err = next_s.err | err_events; // [RULE_18]
    // a read in the same cycle as a clear re-arms with what it returned
    if (err_rd) begin
      next_s.err_seen = s.err; // [RULE_18]
    end
    // warning flags follow the same read-then-clear scheme
    if (warn_clr) begin
      next_s.warn = s.warn & ~s.warn_seen; // [RULE_02] [RULE_26]
      next_s.warn_seen = 12'h000;
    end
    next_s.warn = next_s.warn | warning_events;
    if (warn_rd) begin
      next_s.warn_seen = s.warn;
    end
  end

  // state register
  always_ff @(posedge clock) begin
    if (!rstn) begin
      s <= ST_RESET;
    end else begin
      s <= next_s;
    end
  end

  // outputs from flip-flops
  assign reg_rdata = s.rdata;
  assign start_frontend_test = s.fe_start;
  assign start_logic_test = s.logic_start;
  assign turns_counter_reset = s.turns_reset;
  assign hard_reset_request = s.hard_reset;

endmodule

// ---- core/asr_pkg.sv ----
// constants and register map of the angle, status and error register group
// Behaviour
// [RULE_01] status-clear write clears action-done and boot-done status bits
// [RULE_02] warning-clear write clears only warning bits returned by earlier read; reads zero
// [RULE_03] error-clear write clears only error bits returned by earlier read; reads zero
// [RULE_04] trigger byte starts selected action: B9 tests, 46 turns reset, 5A reset
// [RULE_05] angle word top bit zero, low twelve bits carry processed angle code
// [RULE_06] error-summary bit is one when any unmasked error or warning bit set
// [RULE_07] undervoltage bit is live OR of analog and digital indications, each maskable
// [RULE_08] parity bit makes whole sixteen-bit angle word hold odd count of ones
// [RULE_09] status and error registers return fixed identifiers in top four bits
// [RULE_10] two-bit die identifier loaded from nonvolatile memory at boot
// [RULE_11] status bit reports rotation direction, zero increasing, one decreasing
// [RULE_12] status bit set when rotation too fast for low-power sleep entry
// [RULE_13] action-done clears when a command triggers, sets when it completes
// [RULE_14] boot-done sets after load and start-up tests, holds until status clear
// [RULE_15] two status bits show logic and front-end self-tests running
// [RULE_16] status bit reads one while boot sequence is underway
// [RULE_17] angle-valid reads one only when loop locked and start-up complete
// [RULE_18] error flags latch until read and then cleared by the host
// [RULE_19] warning-summary error bit sets on unmasked warning, maskable itself
// [RULE_20] error bits flag self-test failure and averaging error
// [RULE_21] error bits latch quadrature, lock, zero-crossing, memory, oscillator, supply faults
// [RULE_22] supply undervoltage error keeps re-asserting while the fault persists
// [RULE_23] multi-bit memory errors flagged only while memory contents are loading
// [RULE_24] lowest error bit sets on power-on or hard reset, not self-test
// [RULE_25] action codes select front-end, logic or both self-tests, started by B9
// [RULE_26] flag set after last read survives the next clear strobe
package asr_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h1E;
  localparam logic [7:0] ANGLE_OFS = 8'h20;
  localparam logic [7:0] STATUS_OFS = 8'h22;
  localparam logic [7:0] ERROR_OFS = 8'h24;
  localparam logic [7:0] WARN_OFS = 8'h26;
  // control field positions
  localparam int SEL_LSB = 12;
  localparam int STATUS_CLR_BIT = 10;
  localparam int WARN_CLR_BIT = 9;
  localparam int ERROR_CLR_BIT = 8;
  // fixed register identifiers
  localparam logic [3:0] STATUS_ID = 4'h8;
  localparam logic [3:0] ERROR_ID = 4'hA;
  localparam logic [3:0] WARN_ID = 4'hB;
  // action select codes
  localparam logic [3:0] ACT_NONE = 4'h0;
  localparam logic [3:0] ACT_TURNS = 4'h4;
  localparam logic [3:0] ACT_HARD = 4'h7;
  localparam logic [3:0] ACT_FE_TEST = 4'h9;
  localparam logic [3:0] ACT_LOGIC_TEST = 4'hA;
  localparam logic [3:0] ACT_BOTH_TEST = 4'hB;
  // trigger bytes
  localparam logic [7:0] TRIG_TEST = 8'hB9;
  localparam logic [7:0] TRIG_TURNS = 8'h46;
  localparam logic [7:0] TRIG_HARD = 8'h5A;
  // error bit positions
  localparam int ERR_WAR = 11;
  localparam int ERR_UVD = 3;
  localparam int ERR_UVA = 2;
  localparam int ERR_RST = 0;
  // reset values
  localparam logic [11:0] ERROR_RESET = 12'h001;
  localparam logic [11:0] WARN_RESET = 12'h000;
  localparam logic [3:0] SEL_RESET = 4'h0;
endpackage

// ---- bench/asr_regs_asserts.sv ----
// port checker for the register group
module asr_regs_chk
  import asr_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic [11:0] angle_code,
  input wire logic uvd_level,
  input wire logic uva_level,
  input wire logic [11:0] error_mask,
  input wire logic error_summary,
  input wire logic rotation_direction,
  input wire logic boot_in_progress,
  input wire logic loop_locked,
  input wire logic startup_complete,
  input wire logic start_frontend_test,
  input wire logic start_logic_test,
  input wire logic turns_counter_reset,
  input wire logic hard_reset_request
);
  timeunit 1ns;
  timeprecision 1ns;
  // decoded accesses; read data lands one cycle after the strobe
  wire rd_ang = reg_rd && reg_addr == ANGLE_OFS;
  wire rd_sta = reg_rd && reg_addr == STATUS_OFS;
  wire rd_err = reg_rd && reg_addr == ERROR_OFS;
  wire wr_ctl = reg_wr && reg_addr == CTRL_OFS;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  angle_word_a: assert property (
    $past(rd_ang) |-> !reg_rdata[15] && reg_rdata[11:0] == $past(angle_code))
    else $error("angle word wrong");
  parity_odd_a: assert property ($past(rd_ang) |-> ^reg_rdata)
    else $error("angle parity even");
  summary_a: assert property (
    $past(rd_ang) |-> reg_rdata[14] == $past(error_summary))
    else $error("summary bit differs");
  uv_live_a: assert property (
    $past(rd_ang) |-> reg_rdata[13] ==
      $past(uvd_level && !error_mask[3] || uva_level && !error_mask[2]))
    else $error("undervoltage bit wrong");
  status_live_a: assert property (
    $past(rd_sta) |-> reg_rdata[15:12] == STATUS_ID && reg_rdata[7] == $past(rotation_direction)
      && reg_rdata[1:0] == $past({boot_in_progress, loop_locked && startup_complete}))
    else $error("status word wrong");
  error_id_a: assert property ($past(rd_err) |-> reg_rdata[15:12] == ERROR_ID)
    else $error("error id wrong");
  fe_start_a: assert property (
    $past(wr_ctl && reg_wdata[15:12] == ACT_FE_TEST) |->
      start_frontend_test == ($past(reg_wdata[7:0]) == TRIG_TEST))
    else $error("front-end start wrong");
  both_start_a: assert property (
    wr_ctl && reg_wdata == {ACT_BOTH_TEST, 4'h0, TRIG_TEST} |=>
      start_logic_test && start_frontend_test)
    else $error("parallel tests not started");
  turns_start_a: assert property (
    wr_ctl && reg_wdata == {ACT_TURNS, 4'h0, TRIG_TURNS} |=>
      turns_counter_reset && !hard_reset_request)
    else $error("turns reset not started");
  pulse_cause_a: assert property (!$past(wr_ctl) |-> !(start_frontend_test ||
    start_logic_test || turns_counter_reset || hard_reset_request))
    else $error("action pulse without write");
endmodule

bind asr_regs asr_regs_chk i_asr_regs_chk (.*);

// ---- bench/asr_host.sv ----
// host model that makes register accesses
module asr_host (
  input wire logic clock,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [15:0] reg_wdata,
  output logic reg_rd
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {reg_addr, reg_wr, reg_wdata, reg_rd} = '0;
  end
  // one-cycle strobe; idle bus inverted so stale values never look valid
  task acc(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    #1 {reg_addr, reg_wdata, reg_wr, reg_rd} = {a, d, w, !w};
    @(posedge clock);
    #1 {reg_addr, reg_wdata, reg_wr, reg_rd} = {~a, ~d, 2'b00};
  endtask
endmodule

// ---- bench/asr_regs_tb.sv ----
// testbench of the register group with read-result queue
module asr_regs_tb import asr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, rstn, uvd_level, uva_level, nvm_multibit_error, nvm_loading, magnet_low_fault;
  logic boot_complete, nvm_loaded, action_complete, rd_seen, wr_seen;
  logic [3:0] exp_p, exp_pq;
  logic [11:0] angle_code, error_mask, warning_mask, warning_events;
  logic [1:0] nvm_die_identifier;
  logic [5:0] src;
  logic [6:0] st;
  logic [31:0] seed;
  logic [15:0] exp_q[$];
  logic [15:0] cmd[5] = '{16'hA0B9, 16'hB0B9, 16'h4046, 16'h705A, 16'h9046};
  int pos[6] = '{4, 6, 7, 8, 9, 10};
  int err_count, samples_checked, cycles;
  wire selftest_failed, averaging_fault, quadrature_integrity_fault, loop_lock_lost;
  wire zero_crossing_timeout, oscillator_watchdog_fault, rotation_direction, too_fast_for_sleep;
  wire logic_selftest_running, frontend_selftest_running, boot_in_progress, loop_locked;
  wire startup_complete, reg_wr, reg_rd, start_frontend_test, start_logic_test;
  wire turns_counter_reset, hard_reset_request, error_summary;
  wire [3:0] pulses = {start_frontend_test, start_logic_test, turns_counter_reset,
    hard_reset_request};
  wire [7:0] reg_addr;
  wire [15:0] reg_wdata, reg_rdata;
  assign {selftest_failed, averaging_fault, quadrature_integrity_fault, loop_lock_lost,
    zero_crossing_timeout, oscillator_watchdog_fault} = src;
  assign {rotation_direction, too_fast_for_sleep, logic_selftest_running,
    frontend_selftest_running, boot_in_progress, loop_locked, startup_complete} = st;
  asr_regs i_asr_regs (.*);
  asr_host i_asr_host (.*);
  initial begin
    clock = 0;
    forever #5 clock = ~clock;
  end
  task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task stop_test;
    if (err_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task rd(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    i_asr_host.acc(1'b0, a, 16'h0000);
  endtask
  // expected action pulses follow from select and trigger of the same word
  task wr(input logic [15:0] d);
    logic [3:0] sel;
    sel = d[15:12];
    exp_p = 4'h0;
    if (d[7:0] == TRIG_TEST) begin
      exp_p[3] = sel == ACT_FE_TEST || sel == ACT_BOTH_TEST;
      exp_p[2] = sel == ACT_LOGIC_TEST || sel == ACT_BOTH_TEST;
    end
    exp_p[1] = sel == ACT_TURNS && d[7:0] == TRIG_TURNS;
    exp_p[0] = sel == ACT_HARD && d[7:0] == TRIG_HARD;
    i_asr_host.acc(1'b1, CTRL_OFS, d);
  endtask
  task done_pulse;
    action_complete = 1;
    tick(1);
    action_complete = 0;
  endtask
  function automatic logic [15:0] angle_reading(logic ef, logic uv, logic [11:0] a);
    return {1'b0, ef, uv, ~^{ef, uv, a}, a};
  endfunction
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // oldest note is compared one cycle after each read strobe; hang guard too
  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      stop_test;
    end
    if (rd_seen) check("reg_rdata", reg_rdata, exp_q.pop_front());
    if (wr_seen) check("pulses", {12'h000, pulses}, {12'h000, exp_pq});
    rd_seen <= reg_rd;
    wr_seen <= reg_wr;
    // latched at the write edge so a following write cannot overtake it
    exp_pq <= exp_p;
  end
  initial begin
    {rstn, uvd_level, uva_level, nvm_multibit_error, nvm_loading, magnet_low_fault} = '0;
    {boot_complete, nvm_loaded, action_complete, rd_seen, wr_seen, st, src} = '0;
    {exp_p, exp_pq} = '0;
    {angle_code, error_mask, warning_mask, warning_events, nvm_die_identifier} = '0;
    seed = 32'hB2E87E80;
    tick(4);
    rstn = 1;
    rd(ERROR_OFS, 16'hA001);
    rd(WARN_OFS, 16'hB000);
    st = 7'h7F;
    rd(STATUS_OFS, 16'h80CF);
    st = 7'h7E;
    rd(STATUS_OFS, 16'h80CE);
    st = 7'h00;
    wr(16'h0100);
    // each source latched, then read and cleared
    for (int i = 0; i < 6; i++) begin
      src = 6'h01 << i;
      tick(1);
      src = 0;
      rd(ERROR_OFS, 16'hA000 | (16'h0001 << pos[i]));
      wr(16'h0100);
      rd(ERROR_OFS, 16'hA000);
    end
    // a fault after the read survives the clear
    src = 6'h04;
    tick(1);
    src = 6'h00;
    rd(ERROR_OFS, 16'hA080);
    src = 6'h02;
    tick(1);
    src = 6'h00;
    wr(16'h0100);
    rd(ERROR_OFS, 16'hA040);
    wr(16'h0100);
    uvd_level = 1;
    angle_code = 12'h123;
    rd(ANGLE_OFS, angle_reading(1'b1, 1'b1, 12'h123));
    rd(ERROR_OFS, 16'hA008);
    wr(16'h0100);
    rd(ERROR_OFS, 16'hA008);
    uvd_level = 0;
    wr(16'h0100);
    rd(ERROR_OFS, 16'hA000);
    nvm_multibit_error = 1;
    tick(1);
    rd(ERROR_OFS, 16'hA000);
    nvm_loading = 1;
    tick(1);
    {nvm_multibit_error, nvm_loading} = 2'b00;
    rd(ERROR_OFS, 16'hA020);
    wr(16'h0100);
    // die_identifier captured at load, not followed live
    nvm_die_identifier = 2'b10;
    {boot_complete, nvm_loaded} = 2'b11;
    tick(1);
    {boot_complete, nvm_loaded, nvm_die_identifier} = 4'b0001;
    rd(STATUS_OFS, 16'h8210);
    done_pulse();
    rd(STATUS_OFS, 16'h8230);
    wr(16'h90B9);
    rd(STATUS_OFS, 16'h8210);
    rd(CTRL_OFS, 16'h9000);
    done_pulse();
    rd(CTRL_OFS, 16'h0000);
    wr(16'h0400);
    rd(STATUS_OFS, 16'h8200);
    foreach (cmd[i]) begin
      wr(cmd[i]);
      done_pulse();
    end
    warning_events = 12'h001;
    tick(1);
    warning_events = 12'h000;
    rd(WARN_OFS, 16'hB001);
    rd(ERROR_OFS, 16'hA800);
    wr(16'h0200);
    rd(WARN_OFS, 16'hB000);
    // masked warning summary stays out of the error register
    error_mask = 12'h800;
    warning_events = 12'h002;
    tick(1);
    warning_events = 12'h000;
    wr(16'h0100);
    rd(ERROR_OFS, 16'hA000);
    // random angles with every flag masked
    {error_mask, warning_mask} = '1;
    repeat (20) begin
      seed = xs(seed);
      {uvd_level, uva_level, angle_code} = seed[13:0];
      rd(ANGLE_OFS, angle_reading(1'b0, 1'b0, seed[11:0]));
    end
    tick(3);
    stop_test;
  end
endmodule
